// >>> rtl/bst_map.vh
// constants for the boundary-scan test access port
`ifndef BST_MAP_VH
`define BST_MAP_VH
`define BST_IR_LEN 10
`define BST_IR_CAPTURE 10'h001
`define BST_OP_EXTEST 10'h000
`define BST_OP_SAMPLE 10'h005
`define BST_OP_IDCODE 10'h006
`define BST_OP_USERCODE 10'h007
`define BST_OP_CFG_LOAD 10'h002
`define BST_OP_CFG_START 10'h003
`define BST_OP_BYPASS 10'h3FF
`define BST_ID_LEN 32
`define BST_USER_LEN 32
`define BST_USER_FIELD 7
`define BST_USER_FIXED 25
`define BST_BSR_LEN_DEF 438
`define BST_ID_ONE_POS 0
`endif

// >>> rtl/bst_sync.v
// two-flop synchroniser for signals from outside the core clock domain
module bst_sync #(
  parameter WIDTH = 1
) (
  input wire core_clk_in,
  input wire reset_n_in,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta;

  // first stage only feeds the second stage
  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule // bst_sync

// >>> rtl/bst_tap.v
// boundary-scan test access port with id, user signature and config chains
`include "bst_map.vh"

module bst_tap #(
  parameter BSR_LEN = `BST_BSR_LEN_DEF,
  parameter [3:0] ID_VERSION = 4'h5, // arbitrary value
  parameter [15:0] ID_PART = 16'h4C2A, // arbitrary value
  parameter [10:0] ID_MAKER = 11'h2B3, // arbitrary value
  parameter [24:0] USER_FIXED = 25'h0A5A5A5 // arbitrary value
) (
  input wire core_clk_in,
  input wire reset_n_in,
  input wire tck_in,
  input wire tms_in,
  input wire tdi_in,
  input wire [BSR_LEN-1:0] pin_level_in,
  input wire [`BST_USER_FIELD-1:0] user_sig_in,
  input wire cfg_busy_in,
  output reg tdo_out,
  output reg tdo_oe_out,
  output reg [BSR_LEN-1:0] bsr_drive_out,
  output reg extest_active_out,
  output reg cfg_bit_out,
  output reg cfg_bit_valid_out,
  output reg cfg_start_out
);
  // one-hot controller states
  localparam [15:0] S_RESET = 16'h0001;
  localparam [15:0] S_IDLE = 16'h0002;
  localparam [15:0] S_SEL_DR = 16'h0004;
  localparam [15:0] S_CAP_DR = 16'h0008;
  localparam [15:0] S_SH_DR = 16'h0010;
  localparam [15:0] S_EX1_DR = 16'h0020;
  localparam [15:0] S_PAU_DR = 16'h0040;
  localparam [15:0] S_EX2_DR = 16'h0080;
  localparam [15:0] S_UPD_DR = 16'h0100;
  localparam [15:0] S_SEL_IR = 16'h0200;
  localparam [15:0] S_CAP_IR = 16'h0400;
  localparam [15:0] S_SH_IR = 16'h0800;
  localparam [15:0] S_EX1_IR = 16'h1000;
  localparam [15:0] S_PAU_IR = 16'h2000;
  localparam [15:0] S_EX2_IR = 16'h4000;
  localparam [15:0] S_UPD_IR = 16'h8000;
  // data register selections
  localparam [2:0] SEL_BYP = 3'h0;
  localparam [2:0] SEL_BSR = 3'h1;
  localparam [2:0] SEL_ID = 3'h2;
  localparam [2:0] SEL_USR = 3'h3;
  localparam [2:0] SEL_CFG = 3'h4;

  wire [2:0] jtag_sync;
  wire [BSR_LEN-1:0] pin_sync;
  wire tck_s = jtag_sync[2];
  wire tms_s = jtag_sync[1];
  wire tdi_s = jtag_sync[0];
  reg tck_prev;
  reg [15:0] state;
  reg [15:0] next_state;
  reg [`BST_IR_LEN-1:0] ir_shift;
  reg [`BST_IR_LEN-1:0] ir_active;
  reg byp_reg;
  reg [`BST_ID_LEN-1:0] id_shift;
  reg [`BST_USER_LEN-1:0] usr_shift;
  reg [BSR_LEN-1:0] bsr_shift;
  reg cfg_reg;
  wire tck_rise = tck_s & ~tck_prev;
  wire tck_fall = ~tck_s & tck_prev;
  wire [`BST_ID_LEN-1:0] id_value = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
  wire [`BST_USER_LEN-1:0] usr_value = {USER_FIXED, user_sig_in};
  wire [2:0] dr_sel = decode_sel(ir_active, cfg_busy_in);
  wire bsr_op = (dr_sel == SEL_BSR);

  // instruction decode; scan ops refused while configuring
  function [2:0] decode_sel;
    input [`BST_IR_LEN-1:0] op;
    input busy;
    begin
      case (op)
        `BST_OP_EXTEST: decode_sel = busy ? SEL_BYP : SEL_BSR;
        `BST_OP_SAMPLE: decode_sel = busy ? SEL_BYP : SEL_BSR;
        `BST_OP_IDCODE: decode_sel = SEL_ID;
        `BST_OP_USERCODE: decode_sel = SEL_USR;
        `BST_OP_CFG_LOAD: decode_sel = SEL_CFG;
        default: decode_sel = SEL_BYP;
      endcase
    end
  endfunction

  bst_sync #(.WIDTH(3)) u_jtag_sync (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .async_in({tck_in, tms_in, tdi_in}),
    .sync_out(jtag_sync)
  );

  bst_sync #(.WIDTH(BSR_LEN)) u_pin_sync (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .async_in(pin_level_in),
    .sync_out(pin_sync)
  );

  // sixteen-state controller transitions
  always @* begin
    case (state)
      S_RESET: next_state = tms_s ? S_RESET : S_IDLE;
      S_IDLE: next_state = tms_s ? S_SEL_DR : S_IDLE;
      S_SEL_DR: next_state = tms_s ? S_SEL_IR : S_CAP_DR;
      S_CAP_DR: next_state = tms_s ? S_EX1_DR : S_SH_DR;
      S_SH_DR: next_state = tms_s ? S_EX1_DR : S_SH_DR;
      S_EX1_DR: next_state = tms_s ? S_UPD_DR : S_PAU_DR;
      S_PAU_DR: next_state = tms_s ? S_EX2_DR : S_PAU_DR;
      S_EX2_DR: next_state = tms_s ? S_UPD_DR : S_SH_DR;
      S_UPD_DR: next_state = tms_s ? S_SEL_DR : S_IDLE;
      S_SEL_IR: next_state = tms_s ? S_RESET : S_CAP_IR;
      S_CAP_IR: next_state = tms_s ? S_EX1_IR : S_SH_IR;
      S_SH_IR: next_state = tms_s ? S_EX1_IR : S_SH_IR;
      S_EX1_IR: next_state = tms_s ? S_UPD_IR : S_PAU_IR;
      S_PAU_IR: next_state = tms_s ? S_EX2_IR : S_PAU_IR;
      S_EX2_IR: next_state = tms_s ? S_UPD_IR : S_SH_IR;
      S_UPD_IR: next_state = tms_s ? S_SEL_DR : S_IDLE;
      default: next_state = S_RESET;
    endcase
  end

  // rising test-clock work: state, capture, shift, update
  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tck_prev <= 1'b0;
      state <= S_RESET;
      ir_shift <= `BST_IR_CAPTURE;
      ir_active <= `BST_OP_IDCODE;
      byp_reg <= 1'b0;
      id_shift <= {`BST_ID_LEN{1'b0}};
      usr_shift <= {`BST_USER_LEN{1'b0}};
      bsr_shift <= {BSR_LEN{1'b0}};
      cfg_reg <= 1'b0;
      bsr_drive_out <= {BSR_LEN{1'b0}};
      cfg_bit_out <= 1'b0;
      cfg_bit_valid_out <= 1'b0;
      cfg_start_out <= 1'b0;
    end else begin
      tck_prev <= tck_s;
      cfg_bit_valid_out <= 1'b0;
      cfg_start_out <= 1'b0;
      if (tck_rise) begin
        state <= next_state;
        case (state)
          S_RESET: ir_active <= `BST_OP_IDCODE;
          S_CAP_IR: ir_shift <= `BST_IR_CAPTURE;
          S_SH_IR: ir_shift <= {tdi_s, ir_shift[`BST_IR_LEN-1:1]};
          S_UPD_IR: begin
            ir_active <= ir_shift;
            cfg_start_out <= (ir_shift == `BST_OP_CFG_START);
          end
          S_CAP_DR: begin
            byp_reg <= 1'b0;
            id_shift <= id_value;
            usr_shift <= usr_value;
            if (bsr_op) begin
              bsr_shift <= pin_sync;
            end
          end
          S_SH_DR: begin
            case (dr_sel)
              SEL_BSR: bsr_shift <= {tdi_s, bsr_shift[BSR_LEN-1:1]};
              SEL_ID: id_shift <= {tdi_s, id_shift[`BST_ID_LEN-1:1]};
              SEL_USR: usr_shift <= {tdi_s, usr_shift[`BST_USER_LEN-1:1]};
              SEL_CFG: begin
                cfg_reg <= tdi_s;
                cfg_bit_out <= tdi_s;
                cfg_bit_valid_out <= 1'b1;
              end
              default: byp_reg <= tdi_s;
            endcase
          end
          S_UPD_DR: begin
            if (bsr_op) begin
              bsr_drive_out <= bsr_shift;
            end
          end
          default: ir_shift <= ir_shift;
        endcase
      end
    end
  end

  // falling test-clock work: serial output and enable; pin drive mode every core clock
  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tdo_out <= 1'b0;
      tdo_oe_out <= 1'b0;
      extest_active_out <= 1'b0;
    end else begin
      extest_active_out <= (ir_active == `BST_OP_EXTEST) && !cfg_busy_in;
      if (tck_fall) begin
        tdo_oe_out <= (state == S_SH_DR) || (state == S_SH_IR);
        if (state == S_SH_IR) begin
          tdo_out <= ir_shift[0];
        end else begin
          case (dr_sel)
            SEL_BSR: tdo_out <= bsr_shift[0];
            SEL_ID: tdo_out <= id_shift[0];
            SEL_USR: tdo_out <= usr_shift[0];
            SEL_CFG: tdo_out <= cfg_reg;
            default: tdo_out <= byp_reg;
          endcase
        end
      end
    end
  end
endmodule // bst_tap

// >>> testbench/bst_tap_asserts.sv
// checker for the boundary-scan port outputs
module bst_tap_chk (
  input wire core_clk_in,
  input wire reset_n_in,
  input wire tck_in,
  input wire cfg_busy_in,
  input wire tdo_out,
  input wire tdo_oe_out,
  input wire extest_active_out,
  input wire cfg_bit_valid_out,
  input wire cfg_start_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  // serial output moves only after a test clock fall
  property p_tdo_fall; $changed(tdo_out) |-> !tck_in && !$past(tck_in, 3); endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved off a fall");
  property p_oe_fall; $changed(tdo_oe_out) |-> !tck_in; endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("oe moved off a fall");
  // test clock high is only four core samples long, so look two back
  property p_tdo_hold; tck_in && $past(tck_in, 2) |-> $stable(tdo_out); endproperty
  a_tdo_hold: assert property (p_tdo_hold) else $error("tdo moved while high");
  // external test refused while configuring
  property p_busy; cfg_busy_in && $past(cfg_busy_in) |-> !extest_active_out; endproperty
  a_busy: assert property (p_busy) else $error("extest during config");
  property p_ext_rise; $rose(extest_active_out) |-> !$past(cfg_busy_in); endproperty
  a_ext_rise: assert property (p_ext_rise) else $error("extest rose while busy");
  // config strobes
  property p_valid; $rose(cfg_bit_valid_out) |=> $fell(cfg_bit_valid_out); endproperty
  a_valid: assert property (p_valid) else $error("valid not one cycle");
  property p_valid_shift; cfg_bit_valid_out |-> tdo_oe_out && tck_in; endproperty
  a_valid_shift: assert property (p_valid_shift) else $error("valid off shift");
  property p_start; cfg_start_out |-> !tdo_oe_out ##1 !cfg_start_out; endproperty
  a_start: assert property (p_start) else $error("start pulse wrong");
endmodule // bst_tap_chk
bind bst_tap bst_tap_chk chk (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
  .tck_in(tck_in), .cfg_busy_in(cfg_busy_in), .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out),
  .extest_active_out(extest_active_out), .cfg_bit_valid_out(cfg_bit_valid_out),
  .cfg_start_out(cfg_start_out));

// >>> testbench/bst_tester.sv
// test controller model driving the scan port
module bst_tester (
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out,
  input wire logic tdo_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // clock rests low between frames
  initial begin
    tck_out = 0;
    tms_out = 1;
    tdi_out = 0;
  end
  // one clock: change on fall, sample on rise
  task automatic step(input logic m, input logic d, output logic q);
    tms_out = m;
    tdi_out = d;
    #160;
    q = tdo_in;
    tck_out = 1;
    #160;
    tck_out = 0;
  endtask
  // idle to shift, n bits lsb first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [63:0] din,
    output logic [63:0] dout);
    logic q;
    dout = '0;
    step(1, 0, q);
    if (ir) step(1, 0, q);
    step(0, 0, q);
    step(0, 0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1, 0, q);
    step(0, 0, q);
  endtask
endmodule // bst_tester

// >>> testbench/testbench.sv
// self-checking bench for the boundary-scan port
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] VER = 4'h3; // arbitrary value
  localparam logic [15:0] PART = 16'h1234; // arbitrary value
  localparam logic [10:0] MAKER = 11'h0AB; // arbitrary value
  localparam logic [24:0] UFIX = 25'h1ABCDEF; // arbitrary value
  logic core_clk, reset_n, busy, tck, tms, tdi, tdo, oe, ext, cbit, cval, cstart;
  logic [7:0] pins, drive, cfg_data;
  logic [6:0] usig;
  logic [63:0] q;
  int fails, check_count, cfg_cnt, start_cnt;
  bst_tap #(.BSR_LEN(8), .ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER),
    .USER_FIXED(UFIX)) uut (.core_clk_in(core_clk), .reset_n_in(reset_n), .tck_in(tck),
    .tms_in(tms), .tdi_in(tdi), .pin_level_in(pins), .user_sig_in(usig), .cfg_busy_in(busy),
    .tdo_out(tdo), .tdo_oe_out(oe), .bsr_drive_out(drive), .extest_active_out(ext),
    .cfg_bit_out(cbit), .cfg_bit_valid_out(cval), .cfg_start_out(cstart));
  bst_tester tester (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo));
  // collect the config stream
  always @(posedge core_clk) begin
    if (cval) cfg_data <= {cbit, cfg_data[7:1]};
    cfg_cnt <= cfg_cnt + int'(cval);
    start_cnt <= start_cnt + int'(cstart);
  end
  task automatic chk(string name, logic [63:0] seen, logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic ir(logic [9:0] op);
    tester.scan(1, 10, 64'(op), q);
    chk("ir capture", q, 64'h001);
  endtask
  task automatic t_id;
    logic b;
    repeat (5) tester.step(1, 0, b);
    tester.step(0, 0, b);
    tester.scan(0, 32, 0, q);
    chk("idcode", q, {VER, PART, MAKER, 1'b1});
    ir(10'h007);
    tester.scan(0, 32, 0, q);
    chk("user", q, {UFIX, usig});
  endtask
  // bypass delay, output enable inside a frame, unassigned code
  task automatic t_bypass;
    logic b;
    ir(10'h3FF);
    tester.scan(0, 8, 64'hB3, q);
    chk("bypass", q, 64'h66);
    tester.step(1, 0, b);
    tester.step(0, 0, b);
    tester.step(0, 0, b);
    #200;
    chk("oe shift", 64'(oe), 64'h1);
    tester.step(1, 0, b);
    tester.step(1, 0, b);
    tester.step(0, 0, b);
    chk("oe idle", 64'(oe), 64'h0);
    ir(10'h155);
    tester.scan(0, 8, 64'hB3, q);
    chk("unassigned", q, 64'h66);
  endtask
  task automatic t_scan(logic [9:0] op, logic [7:0] pv, logic [7:0] pat);
    @(posedge core_clk) #1 pins = pv;
    ir(op);
    chk("extest level", 64'(ext), 64'(op == 10'h000));
    tester.scan(0, 8, 64'(pat), q);
    chk("capture", q, 64'(pv));
    chk("drive", 64'(drive), 64'(pat));
  endtask
  task automatic t_busy;
    @(posedge core_clk) #1 busy = 1;
    ir(10'h000);
    chk("busy extest", 64'(ext), 64'h0);
    tester.scan(0, 2, 64'h1, q);
    chk("busy bypass", q, 64'h2);
    chk("busy drive", 64'(drive), 64'h96);
    @(posedge core_clk) #1 busy = 0;
  endtask
  task automatic t_cfg;
    ir(10'h002);
    tester.scan(0, 8, 64'hC9, q);
    chk("cfg count", 64'(cfg_cnt), 64'd8);
    chk("cfg data", 64'(cfg_data), 64'hC9);
    ir(10'h003);
    chk("cfg start", 64'(start_cnt), 64'd1);
  endtask
  // five mode-high clocks return to test-logic reset and reload id
  task automatic t_tlr;
    logic b;
    repeat (5) tester.step(1, 0, b);
    tester.step(0, 0, b);
    tester.scan(0, 32, 0, q);
    chk("id after tlr", q, {VER, PART, MAKER, 1'b1});
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    core_clk = 0;
    forever #20 core_clk = ~core_clk;
  end
  // main sequence
  initial begin
    reset_n = 0;
    busy = 0;
    pins = 8'h00;
    usig = 7'h4B;
    repeat (3) @(posedge core_clk);
    #1 reset_n = 1;
    repeat (3) @(posedge core_clk);
    #1;
    t_id;
    t_bypass;
    t_scan(10'h005, 8'hA5, 8'h3C);
    t_scan(10'h000, 8'h5A, 8'h96);
    t_busy;
    t_cfg;
    t_tlr;
    end_of_test;
  end
  // watchdog
  initial begin
    #1000000;
    fails++;
    end_of_test;
  end
endmodule // testbench
